// >>> sesp_top.sv
// Two-wire serial EEPROM slave port with a guarded upper half
//
// Contract
// R01: 512 bytes of eight bits held
// R02: Guard high blocks writes to 100h-1FFh
// R03: Slave only, paced by master clock
// R04: Fixed four-bit type code matched
// R05: Start, select byte, then acknowledge
// R06: Device acknowledges each written byte
// R07: Master acknowledges each read byte
// R08: Master stops after ack or no-ack
// R09: Serial clock strobes every data bit
// R10: Data line driven open-drain only
// R11: Chip-select bits compared with straps
// R12: Byte and 16-byte page writes, auto-increment
// R13: Mismatched select returns device to standby
// R14: Last select bit: one read, zero write
// R15: Guarded data bytes left unacknowledged
// R16: Stop after ack starts write; ignore bus
`timescale 1ns/1ns
`default_nettype none
module sesp_top
#(
	parameter int TWR_CYCLES = sesp_pkg::SESP_TWR_CYC // Internal write time in clocks
)
(
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic upper_half_write_guard_i,
	input wire logic chip_select_strap_low_i,
	input wire logic chip_select_strap_high_i,
	output logic busy_o
);
	import sesp_pkg::*;
	// ****************************************
	// Bus sampling
	// ****************************************
	sesp_bus_t bus; // Synchronised lines
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic [2:0] pin_meta_reg; // Strap and guard first stage
	logic [2:0] pin_sync_reg; // Strap and guard second stage
	sesp_sync u_sync
	(
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.bus_o(bus),
		.scl_rise_o(scl_rise),
		.scl_fall_o(scl_fall),
		.start_o(start_c),
		.stop_o(stop_c)
	);
	// Straps and guard come from pins, so they are synchronised too
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pin_meta_reg <= 3'h0;
			pin_sync_reg <= 3'h0;
		end
		else
		begin
			pin_meta_reg <= {upper_half_write_guard_i, chip_select_strap_high_i,
				chip_select_strap_low_i};
			pin_sync_reg <= pin_meta_reg;
		end
	end
	// ****************************************
	// Storage
	// ****************************************
	logic [7:0] mem [0:SESP_DEPTH-1]; // Array of 512 bytes [R01]
	logic [7:0] page_buf [0:SESP_PAGE_BYTES-1]; // Bytes waiting for Stop
	// Upper-half test, used on each data byte
	function automatic logic is_guarded(input logic [8:0] a, input logic g);
		is_guarded = g & (a >= SESP_UPPER_BASE); // [R02]
	endfunction
	// ****************************************
	// Protocol state
	// ****************************************
	sesp_state_t state_reg, state_next;
	logic [2:0] bit_reg, bit_next; // Bit index, msb first
	logic [7:0] shift_reg, shift_next; // Byte shifter
	logic [8:0] addr_reg, addr_next; // Current address
	logic ack_slot_reg, ack_slot_next; // In ninth bit period
	logic ack_drv_reg, ack_drv_next; // Pull low during ack
	logic after_ack_reg, after_ack_next; // Tenth slot: Stop here commits
	logic wr_mode_reg, wr_mode_next; // Select asked for a write
	logic [7:0] rd_data_reg, rd_data_next; // Byte being sent
	logic drive_low_reg, drive_low_next; // Open-drain pull
	sesp_page_t page_reg, page_next; // Pending page
	logic [12:0] twr_reg, twr_next; // Write-cycle countdown
	logic [4:0] cp_reg, cp_next; // Commit pointer during write cycle
	logic buf_we; // Page buffer write strobe
	logic [3:0] buf_idx; // Slot in page buffer
	logic [7:0] full_byte; // Byte with the final bit in
	assign full_byte = {shift_reg[6:0], bus.sda};
	assign buf_idx = page_reg.count[3:0];
	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb
	begin
		state_next = state_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		addr_next = addr_reg;
		ack_slot_next = ack_slot_reg;
		ack_drv_next = ack_drv_reg;
		after_ack_next = after_ack_reg;
		wr_mode_next = wr_mode_reg;
		rd_data_next = rd_data_reg;
		drive_low_next = drive_low_reg;
		page_next = page_reg;
		twr_next = twr_reg;
		cp_next = cp_reg;
		buf_we = 1'b0;
		if (state_reg == SESP_PROG)
		begin
			// Bus lines ignored while programming [R16]
			if (cp_reg < page_reg.count)
				cp_next = cp_reg + 5'h01;
			if (twr_reg == 13'h0000)
			begin
				state_next = SESP_IDLE;
				page_next.count = 5'h00;
			end
			else
				twr_next = twr_reg - 13'h0001;
		end
		else if (start_c)
		begin
			// Start or repeated Start opens a select byte [R05]
			state_next = SESP_SEL;
			bit_next = SESP_BIT_RST;
			ack_slot_next = 1'b0;
			after_ack_next = 1'b0;
			drive_low_next = 1'b0;
			page_next.count = 5'h00;
		end
		else if (stop_c)
		begin
			drive_low_next = 1'b0;
			if (after_ack_reg && wr_mode_reg && page_reg.count != 5'h00)
			begin
				state_next = SESP_PROG; // [R16]
				twr_next = 13'(TWR_CYCLES - 1);
				cp_next = 5'h00;
			end
			else
			begin
				state_next = SESP_IDLE; // Any other slot: nothing written
				page_next.count = 5'h00;
			end
		end
		else if (state_reg != SESP_IDLE && scl_rise)
		begin
			// Data sampled on rising serial clock [R09] [R03]
			if (ack_slot_reg)
			begin
				// Ninth rise: keep the ack so a Stop in the tenth slot can commit
				after_ack_next = ack_drv_reg;
				bit_next = SESP_BIT_RST; // Marks the ninth rise as seen
				if (state_reg == SESP_RACK && bus.sda)
					state_next = SESP_IDLE; // No-ack ends a read [R08]
			end
			else
			begin
				shift_next = full_byte;
				if (bit_reg == 3'h0)
				begin
					ack_drv_next = 1'b0;
					case (state_reg)
						SESP_SEL:
						begin
							// Type code, straps and direction [R04] [R11] [R14]
							if (full_byte[7:SESP_SEL_TYPE_LSB] == SESP_TYPE_ID &&
								full_byte[SESP_SEL_CS_HI] == pin_sync_reg[1] &&
								full_byte[SESP_SEL_CS_LO] == pin_sync_reg[0])
							begin
								ack_drv_next = 1'b1;
								wr_mode_next = ~full_byte[SESP_SEL_RW];
								addr_next[8] = full_byte[SESP_SEL_A8];
							end
							else
								state_next = SESP_IDLE; // Standby [R13]
						end
						SESP_ADDR:
						begin
							ack_drv_next = 1'b1;
							addr_next = {addr_reg[8], full_byte};
							page_next.addr = {addr_reg[8], full_byte};
						end
						SESP_WDATA:
						begin
							// Guarded bytes get no ack and are dropped [R15] [R02]
							if (!is_guarded(addr_reg, pin_sync_reg[2]))
							begin
								ack_drv_next = 1'b1;
								buf_we = 1'b1;
								if (page_reg.count != 5'(SESP_PAGE_BYTES))
									page_next.count = page_reg.count + 5'h01; // [R12]
								addr_next = {addr_reg[8:SESP_PAGE_BITS],
									4'(addr_reg[3:0] + 4'h1)}; // [R12]
							end
						end
						SESP_RDATA:
							state_next = SESP_RACK; // Master answers [R07]
						default:
							state_next = SESP_IDLE;
					endcase
					ack_slot_next = 1'b1;
				end
				else
					bit_next = bit_reg - 3'h1;
			end
		end
		else if (state_reg != SESP_IDLE && scl_fall)
		begin
			// The data line drive changes only while the clock is low [R09]
			if (!ack_slot_reg)
			begin
				// Tenth fall without Stop: a later Stop writes nothing
				after_ack_next = 1'b0;
				if (state_reg == SESP_RDATA)
					drive_low_next = ~rd_data_reg[bit_reg]; // Next read bit, msb first
			end
			else if (bit_reg == 3'h0)
				// Eighth fall: pull for our ack, release for the master's [R06]
				drive_low_next = ack_drv_reg;
			else
			begin
				// Ninth period over: leave the ack slot, refused data bytes included
				ack_slot_next = 1'b0;
				drive_low_next = 1'b0;
				case (state_reg)
					SESP_SEL:
						state_next = wr_mode_reg ? SESP_ADDR : SESP_RDATA;
					SESP_ADDR:
						state_next = SESP_WDATA;
					SESP_RACK:
						state_next = SESP_RDATA;
					default:
						state_next = state_reg;
				endcase
				if (!wr_mode_reg && (state_reg == SESP_SEL || state_reg == SESP_RACK))
				begin
					rd_data_next = mem[addr_reg];
					drive_low_next = ~mem[addr_reg][7];
					addr_next = addr_reg + 9'h001; // Sequential read roll-over
				end
			end
		end
	end
	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_reg <= SESP_IDLE; // Standby after reset
			bit_reg <= SESP_BIT_RST;
			shift_reg <= SESP_BYTE_RST;
			addr_reg <= SESP_ADDR_RST;
			ack_slot_reg <= 1'b0;
			ack_drv_reg <= 1'b0;
			after_ack_reg <= 1'b0;
			wr_mode_reg <= 1'b0;
			rd_data_reg <= SESP_BYTE_RST;
			drive_low_reg <= 1'b0;
			page_reg <= '0;
			twr_reg <= 13'h0000;
			cp_reg <= 5'h00;
		end
		else
		begin
			state_reg <= state_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			addr_reg <= addr_next;
			ack_slot_reg <= ack_slot_next;
			ack_drv_reg <= ack_drv_next;
			after_ack_reg <= after_ack_next;
			wr_mode_reg <= wr_mode_next;
			rd_data_reg <= rd_data_next;
			drive_low_reg <= drive_low_next;
			page_reg <= page_next;
			twr_reg <= twr_next;
			cp_reg <= cp_next;
		end
	end
	// Memory arrays have no reset; past 16 bytes the page buffer keeps writing slot 0
	always_ff @(posedge ref_clk_i)
	begin
		if (buf_we)
			page_buf[buf_idx] <= full_byte;
		if (state_reg == SESP_PROG && cp_reg < page_reg.count)
			mem[{page_reg.addr[8:SESP_PAGE_BITS],
				4'(page_reg.addr[3:0] + cp_reg[3:0])}] <= page_buf[cp_reg[3:0]]; // [R12]
	end
	// Open-drain: the line is only ever pulled low or released [R10]
	assign sda_o = 1'b0;
	assign sda_oe_o = drive_low_reg;
	assign busy_o = (state_reg == SESP_PROG);
endmodule
`default_nettype wire

// >>> sesp_pkg.sv
// Shared constants, states and carrier types of the serial EEPROM slave port
package sesp_pkg;
	// ****************************************
	// Array geometry
	// ****************************************
	localparam int SESP_DEPTH = 512;
	localparam int SESP_AW = 9;
	localparam int SESP_DW = 8;
	localparam logic [8:0] SESP_UPPER_BASE = 9'h100; // First guarded location
	localparam int SESP_PAGE_BYTES = 16;
	localparam int SESP_PAGE_BITS = 4;
	// ****************************************
	// Select byte layout
	// ****************************************
	// Device type code; value is arbitrary
	localparam logic [3:0] SESP_TYPE_ID = 4'h5;
	localparam int SESP_SEL_TYPE_LSB = 4;
	localparam int SESP_SEL_CS_HI = 3;
	localparam int SESP_SEL_CS_LO = 2;
	localparam int SESP_SEL_A8 = 1;
	localparam int SESP_SEL_RW = 0;
	// ****************************************
	// Timing and reset values
	// ****************************************
	localparam int SESP_CLK_MHZ = 125;
	localparam int SESP_TWR_US = 5; // Internal write cycle, microseconds
	localparam int SESP_TWR_CYC = SESP_TWR_US * SESP_CLK_MHZ;
	localparam logic [2:0] SESP_BIT_RST = 3'h7;
	localparam logic [8:0] SESP_ADDR_RST = 9'h000;
	localparam logic [7:0] SESP_BYTE_RST = 8'h00;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		SESP_IDLE, SESP_SEL, SESP_ADDR, SESP_WDATA, SESP_RDATA, SESP_RACK, SESP_PROG
	} sesp_state_t;
	typedef struct packed {
		logic scl; // Synchronised clock level
		logic sda; // Synchronised data level
	} sesp_bus_t;
	typedef struct packed {
		logic [8:0] addr; // Page buffer base address
		logic [4:0] count; // Bytes held
	} sesp_page_t;
endpackage

// >>> sesp_sync.sv
// Two-flop synchroniser and edge finder for the serial bus lines
`timescale 1ns/1ns
`default_nettype none
module sesp_sync
(
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output sesp_pkg::sesp_bus_t bus_o,
	output logic scl_rise_o,
	output logic scl_fall_o,
	output logic start_o,
	output logic stop_o
);
	import sesp_pkg::*;
	logic [1:0] meta_reg; // First stage, read only by the second
	logic [1:0] meta_next;
	sesp_bus_t sync_reg; // Second stage
	sesp_bus_t sync_next;
	sesp_bus_t prev_reg; // Previous level for edge finding
	sesp_bus_t prev_next;
	// ****************************************
	// Next-value logic
	// ****************************************
	always_comb
	begin
		meta_next = {scl_i, sda_i};
		sync_next = meta_reg;
		prev_next = sync_reg;
	end
	// Registers; idle bus levels are high
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			meta_reg <= 2'h3;
			sync_reg <= 2'h3;
			prev_reg <= 2'h3;
		end
		else
		begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end
	// Edges and bus conditions seen from the synchronised levels
	assign bus_o = sync_reg;
	assign scl_rise_o = sync_reg.scl & ~prev_reg.scl;
	assign scl_fall_o = ~sync_reg.scl & prev_reg.scl;
	assign start_o = sync_reg.scl & prev_reg.scl & prev_reg.sda & ~sync_reg.sda;
	assign stop_o = sync_reg.scl & prev_reg.scl & ~prev_reg.sda & sync_reg.sda;
endmodule
`default_nettype wire

// >>> sesp_props.sv
// Pin-level checker of the serial EEPROM slave port
`timescale 1ns/1ns
`default_nettype none
module sesp_props
#(
	parameter int TWR_CYCLES = 20 // Internal write time in clocks
)
(
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic upper_half_write_guard_i,
	input wire logic chip_select_strap_low_i,
	input wire logic chip_select_strap_high_i,
	input wire logic busy_o
);
	// ****************************************
	// Helper state
	// ****************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	logic [15:0] busy_cnt_reg; // Length of the running busy spell
	logic [15:0] busy_cnt_next;
	logic seen_start_reg; // Data low under a high clock only follows a start
	logic seen_start_next;
	// Next values of the helper counters
	always_comb
	begin
		busy_cnt_next = busy_o ? busy_cnt_reg + 16'h0001 : 16'h0000;
		seen_start_next = seen_start_reg | (scl_i & ~sda_i);
	end
	// Registering only, cleared by reset
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			busy_cnt_reg <= 16'h0000;
			seen_start_reg <= 1'b0;
		end
		else
		begin
			busy_cnt_reg <= busy_cnt_next;
			seen_start_reg <= seen_start_next;
		end
	end
	// ****************************************
	// Properties
	// ****************************************
	sequence s_stop_level;
		scl_i && sda_i;
	endsequence
	sequence s_clock_low_held;
		!scl_i && !$past(scl_i, 2);
	endsequence
	property p_open_drain; sda_o == 1'b0; endproperty
	property p_pull_wins; sda_oe_o |-> !sda_i; endproperty
	property p_drive_on_low; $changed(sda_oe_o) |-> s_clock_low_held; endproperty
	property p_stand_high; scl_i && $past(scl_i) |-> $stable(sda_oe_o); endproperty
	property p_start_first; sda_oe_o |-> seen_start_reg; endproperty
	property p_busy_on_stop; $rose(busy_o) |-> s_stop_level; endproperty
	property p_busy_deaf; busy_o |-> !sda_oe_o; endproperty
	property p_busy_len; $fell(busy_o) |-> busy_cnt_reg == TWR_CYCLES; endproperty
	property p_busy_hold; $rose(busy_o) |=> busy_o [*8]; endproperty
	a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
	a_pull_wins: assert property (p_pull_wins) else $error("pulled line reads high");
	a_drive_on_low: assert property (p_drive_on_low) else $error("drive changed, clock high");
	a_stand_high: assert property (p_stand_high) else $error("drive moved in clock high");
	a_start_first: assert property (p_start_first) else $error("drive before any start");
	a_busy_on_stop: assert property (p_busy_on_stop) else $error("write cycle without stop");
	a_busy_deaf: assert property (p_busy_deaf) else $error("answered while busy");
	a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
	a_busy_hold: assert property (p_busy_hold) else $error("write cycle cut short");
endmodule
`default_nettype wire

// >>> sesp_master.sv
// Behavioural bus master that clocks the slave port
`timescale 1ns/1ns
`default_nettype none
module sesp_master
(
	input wire logic sda_i,
	output var logic scl_o,
	output var logic sda_low_o
);
	// Clock stands high between frames, data released
	initial
	begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// One bit: data set well after the fall, sampled mid-high
	task automatic bit_io(input logic b, output logic s);
		#16 sda_low_o = ~b;
		#47 scl_o = 1'b1;
		#31 s = sda_i;
		#31 scl_o = 1'b0;
	endtask
	// Data falls while the clock is high
	task automatic start();
		#16 sda_low_o = 1'b0;
		#47 scl_o = 1'b1;
		#31 sda_low_o = 1'b1;
		#31 scl_o = 1'b0;
	endtask
	// Data rises while the clock is high; clock then stands
	task automatic stop();
		#16 sda_low_o = 1'b1;
		#47 scl_o = 1'b1;
		#31 sda_low_o = 1'b0;
		#62;
	endtask
	// Byte out, most significant bit first, line released in the ack slot
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	// Byte in; ack asked pulls the ninth bit, else left high
	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(~ack, s);
	endtask
endmodule
`default_nettype wire

// >>> sesp_top_test.sv
// Self-checking bench of the serial EEPROM slave port
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin miscompares++; \
	$display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module sesp_top_test;
	import sesp_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0; // Active low
	logic guard = 1'b0;
	logic cs_lo;
	logic cs_hi;
	wire logic scl;
	wire logic sda_low;
	wire logic sda;
	wire logic sda_out;
	wire logic sda_oe;
	wire logic busy;
	logic [7:0] mem [SESP_DEPTH]; // Expected array contents
	bit known [SESP_DEPTH]; // Locations with a defined expectation
	int seed = 32'h0e84;
	int checks = 0;
	int miscompares = 0;
	int cyc = 0;
	// Wire-AND of both pull-downs over the pull-up
	assign sda = ~(sda_low | (sda_oe & ~sda_out));
	sesp_top #(.TWR_CYCLES(200)) sesp_top_inst (.ref_clk_i(ref_clk), .resetn_i(resetn),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_out), .sda_oe_o(sda_oe),
		.upper_half_write_guard_i(guard), .chip_select_strap_low_i(cs_lo),
		.chip_select_strap_high_i(cs_hi), .busy_o(busy));
	sesp_master sesp_master_inst (.sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
	// 125 MHz clock and a hang limit well past the run length
	initial
		forever #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 80000)
		begin
			miscompares++;
			end_of_test();
		end
	end
	// Select byte this device should answer
	function automatic logic [7:0] sel(input logic a8, input logic rw);
		return {SESP_TYPE_ID, cs_hi, cs_lo, a8, rw};
	endfunction
	// Page write; guarded data refused; busy spell ignores a select
	task automatic wr(input logic [8:0] a, input int n, input logic g);
		logic ack;
		logic [7:0] d;
		logic [8:0] p;
		logic any;
		any = 1'b0;
		@(negedge ref_clk) guard = g;
		sesp_master_inst.start();
		sesp_master_inst.wbyte(sel(a[8], 1'b0), ack);
		`CHK("select ack", 1'b1, ack)
		sesp_master_inst.wbyte(a[7:0], ack);
		`CHK("address ack", 1'b1, ack)
		for (int i = 0; i < n; i++)
		begin
			p = {a[8:4], a[3:0] + i[3:0]};
			d = $random(seed);
			sesp_master_inst.wbyte(d, ack);
			`CHK("data ack", ~(g & a[8]), ack)
			if (!(g & a[8]))
			begin
				mem[p] = d;
				known[p] = 1'b1;
				any = 1'b1;
			end
		end
		sesp_master_inst.stop();
		`CHK("busy", any, busy)
		if (any)
		begin
			sesp_master_inst.start();
			sesp_master_inst.wbyte(sel(a[8], 1'b0), ack);
			`CHK("busy select ack", 1'b0, ack)
			sesp_master_inst.stop();
			for (int i = 0; i < 400 && busy !== 1'b0; i++)
				@(posedge ref_clk);
			`CHK("busy end", 1'b0, busy)
		end
	endtask
	// Random read: dummy write of the address, restart, sequential bytes
	task automatic rd(input logic [8:0] a, input int n);
		logic ack;
		logic [7:0] d;
		logic [8:0] p;
		sesp_master_inst.start();
		sesp_master_inst.wbyte(sel(a[8], 1'b0), ack);
		sesp_master_inst.wbyte(a[7:0], ack);
		sesp_master_inst.start();
		sesp_master_inst.wbyte(sel(a[8], 1'b1), ack);
		`CHK("read select ack", 1'b1, ack)
		for (int i = 0; i < n; i++)
		begin
			sesp_master_inst.rbyte(i < n - 1, d);
			p = a + i[8:0];
			if (known[p])
				`CHK("read data", mem[p], d)
		end
		sesp_master_inst.stop();
	endtask
	// Verdict and end of run
	task automatic end_of_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Main sequence: selects, edge pages, then random traffic
	initial
	begin
		logic ack;
		logic [8:0] a;
		cs_lo = $random(seed);
		cs_hi = $random(seed);
		repeat (2) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (4) @(negedge ref_clk);
		for (int k = 0; k < 5; k++)
		begin
			sesp_master_inst.start();
			sesp_master_inst.wbyte(sel(1'b0, 1'b0) ^ ((k == 4) ? 8'h10 : {4'h0, k[1:0], 2'b00}), ack);
			`CHK("select match", k == 0, ack)
			sesp_master_inst.stop();
		end
		wr(9'h1f0, 16, 1'b0);
		wr(9'h000, 4, 1'b1);
		wr(9'h1fa, 3, 1'b1);
		rd(9'h1f0, 20);
		repeat (5)
		begin
			a = $random(seed);
			// Fill the page first: an unwritten cell would put an unknown on the line
			wr({a[8:4], 4'h0}, 16, 1'b0);
			wr(a, 1 + ($random(seed) & 15), $random(seed));
			rd({a[8:4], 4'h0}, 16);
		end
		end_of_test();
	end
endmodule
bind sesp_top sesp_props #(.TWR_CYCLES(TWR_CYCLES)) sesp_props_inst (
	.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .scl_i(scl_i), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe_o(sda_oe_o), .upper_half_write_guard_i(upper_half_write_guard_i),
	.chip_select_strap_low_i(chip_select_strap_low_i),
	.chip_select_strap_high_i(chip_select_strap_high_i), .busy_o(busy_o));
`default_nettype wire
